// ==== verification/rtseq_pin_model.sv ====
module rtseq_pin_model (
  // Pins toward the block
  output logic supply_rise,
  output logic master_clear_pin_n,
  output logic rc_clock_in,
  output logic oscillator_input
);
  timeunit 1ns;
  timeprecision 100ps;
  // Free-running RC tick source
  initial begin
    rc_clock_in = 1'b0;
    forever #10 rc_clock_in = ~rc_clock_in;
  end
  // Crystal input, slower than the bus clock
  initial begin
    oscillator_input = 1'b0;
    forever #15 oscillator_input = ~oscillator_input;
  end
  // Power-on pulse, pin held low past the timers
  initial begin
    supply_rise = 1'b1;
    master_clear_pin_n = 1'b0;
    #60 supply_rise = 1'b0;
    #640 master_clear_pin_n = 1'b1;
  end
endmodule

// ==== verification/rtseq_top_tb.sv ====
module rtseq_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, supply_rise, master_clear_pin_n;
  logic rc_clock_in, oscillator_input, master_clear_pin_o, master_clear_pin_oe_n;
  logic watchdog_timeout, sleep_request, irq_wake, core_reset_n, core_run, pc_load;
  logic [31:0] haddr, hwdata, hrdata, q; // Bus and read result
  logic [1:0]  htrans;
  logic [12:0] cpu_pc, pc_load_addr;
  logic [7:0]  status_reg, power_control_register, interrupt_control_register;
  logic [7:0]  port_b_direction_register, timer2_period_register;
  int          mismatches, samples_checked;
  logic        power_up_timer_enable_n, osc_select_hi, osc_select_lo; // Fuses
  // Rows: address and value after power-on
  logic [7:0]  ra [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h40};
  logic [7:0]  rv [6] = '{8'h18, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00};
  rtseq_pin_model i_rtseq_pin_model (.supply_rise, .master_clear_pin_n, .rc_clock_in,
    .oscillator_input);
  rtseq_top #(.POWER_UP_TIMER_RC_TICKS(8), .OST_OSC_CYCLES(4), .MASTER_CLEAR_PIN_FILTER_TICKS(2)) i_rtseq_top (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .supply_rise, .master_clear_pin_n,
    .master_clear_pin_o, .master_clear_pin_oe_n, .rc_clock_in, .oscillator_input,
    .power_up_timer_enable_n, .osc_select_hi, .osc_select_lo,
    .watchdog_timeout, .sleep_request, .irq_wake, .cpu_pc, .core_reset_n, .core_run,
    .pc_load, .pc_load_addr, .status_reg, .power_control_register,
    .interrupt_control_register, .port_b_direction_register, .timer2_period_register);
  // Compare and count
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      $display("[FAIL] %s expected %h seen %h", n, e, s);
      mismatches++;
    end
  endtask
  // One single AHB transfer, waits on hready
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  // One-cycle core event pulse
  task ev(input logic [2:0] m);
    @(posedge hclk);
    {watchdog_timeout, sleep_request, irq_wake} <= m;
    @(posedge hclk);
    {watchdog_timeout, sleep_request, irq_wake} <= 3'h0;
  endtask
  // Bounded wait for the run state
  task wait_run(input int n);
    for (int i = 0; i < n && core_run !== 1'b1; i++) @(posedge hclk);
    chk("core_run", 32'h1, {31'h0, core_run});
  endtask
  task complete_run;
    $display("Checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Bus clock and watchdog
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  initial begin
    #30000 mismatches++;
    complete_run;
  end
  // Main sequence
  initial begin
    {hresetn, hsel, hwrite, watchdog_timeout, sleep_request, irq_wake} = 6'h0;
    {haddr, hwdata, htrans} = 66'h0;
    cpu_pc = 13'h0100;
    {power_up_timer_enable_n, osc_select_hi, osc_select_lo} = 3'b001; // Timer on, XT
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, ra[i], 32'h0);
      chk("reg", {24'h0, rv[i]}, q);
    end
    $display("Test reset values done");
    @(posedge master_clear_pin_n);
    chk("core_reset_n", 32'h0, {31'h0, core_reset_n});
    wait_run(20);
    bus(1'b1, 8'h04, 32'h02);
    bus(1'b1, 8'h0C, 32'h00);
    ev(3'h4);
    @(negedge hclk);
    chk("reset_n", 32'h0, {31'h0, core_reset_n});
    chk("pin_oe_n", 32'h1, {31'h0, master_clear_pin_oe_n});
    chk("pin_o", 32'h1, {31'h0, master_clear_pin_o});
    wait_run(40);
    bus(1'b0, 8'h00, 32'h0);
    chk("to_pd", 32'h1, {30'h0, q[4:3]});
    bus(1'b0, 8'h04, 32'h0);
    chk("pwrctl", 32'h02, q);
    bus(1'b0, 8'h0C, 32'h0);
    chk("dir", 32'hFF, q);
    $display("Test watchdog reset done");
    ev(3'h2);
    ev(3'h1);
    @(negedge hclk);
    chk("pc_load", 32'h1, {31'h0, pc_load});
    repeat (2) @(posedge hclk);
    chk("pc_addr", 32'h101, {19'h0, pc_load_addr});
    wait_run(60);
    bus(1'b0, 8'h00, 32'h0);
    chk("to_pd", 32'h2, {30'h0, q[4:3]});
    bus(1'b0, 8'h10, 32'h0);
    chk("t2", 32'hFF, q);
    $display("Test sleep wake done");
    // Power-on in mid-run, RC mode with the timer off
    bus(1'b1, 8'h14, 32'h5A);
    @(posedge hclk);
    {power_up_timer_enable_n, osc_select_hi, osc_select_lo} <= 3'b111;
    hresetn <= 1'b0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    wait_run(7);
    bus(1'b0, 8'h14, 32'h0);
    chk("scratch", 32'h5A, q);
    bus(1'b0, 8'h04, 32'h0);
    chk("pwrctl", 32'h0, q);
    $display("Test RC start done");
    // Interrupt wake with the global enable set
    bus(1'b1, 8'h08, 32'h80);
    ev(3'h2);
    ev(3'h1);
    @(negedge hclk);
    chk("pc_vec", 32'h4, {19'h0, pc_load_addr});
    wait_run(2);
    $display("Test interrupt vector done");
    complete_run;
  end
endmodule

// ==== verilog/rtseq_pkg.sv ====
package rtseq_pkg;

  // Register byte offsets on the bus
  localparam logic [7:0] OFS_STATUS    = 8'h00;  // Processor status image
  localparam logic [7:0] OFS_PWRCTL    = 8'h04;  // Power control register
  localparam logic [7:0] OFS_INTCTL    = 8'h08;  // Interrupt control register
  localparam logic [7:0] OFS_PORTB_DIR = 8'h0C;  // Port B direction register
  localparam logic [7:0] OFS_T2_PERIOD = 8'h10;  // Timer 2 period register
  localparam logic [7:0] OFS_SCRATCH   = 8'h14;  // Register with no reset action
  localparam logic [7:0] OFS_SEQ_STAT  = 8'h18;  // Sequencer state and last cause

  // Field positions
  localparam int STAT_TO_BIT  = 4;  // Timeout flag, active low
  localparam int STAT_PD_BIT  = 3;  // Power-down flag, active low
  localparam int PWR_POR_BIT  = 1;  // Power-on flag, active low
  localparam int INT_GIE_BIT  = 7;  // Global interrupt enable

  // Values after reset
  localparam logic [7:0] STATUS_POR_VAL  = 8'h18;  // 0001 1xxx, x taken as 0
  localparam logic [7:0] STATUS_RW_MASK  = 8'hE7;  // Flags are hardware only
  localparam logic [7:0] PWRCTL_RST_VAL  = 8'h00;
  localparam logic [7:0] PWRCTL_RW_MASK  = 8'h02;  // Only the power-on flag exists
  localparam logic [7:0] INTCTL_RST_VAL  = 8'h00;
  localparam logic [7:0] DIR_RST_VAL     = 8'hFF;  // All pins inputs
  localparam logic [7:0] T2_PERIOD_VAL   = 8'hFF;
  localparam logic [12:0] PC_RESET_VEC   = 13'h0000;
  localparam logic [12:0] PC_IRQ_VEC     = 13'h0004;

  // Timing
  localparam int POWER_UP_TIMER_TIME_MS   = 72;    // Nominal power-up delay
  localparam int RC_CLOCK_KHZ   = 1000;  // Internal RC clock rate
  localparam int POWER_UP_TIMER_TICKS     = POWER_UP_TIMER_TIME_MS * RC_CLOCK_KHZ;
  localparam int OST_CYCLES     = 1024;  // Oscillator periods before release
  localparam int MASTER_CLEAR_PIN_FILT_TICKS = 4;    // RC ticks a pin level must persist

  // Oscillator select encodings
  localparam logic [1:0] OSC_LP = 2'b00;
  localparam logic [1:0] OSC_XT = 2'b01;
  localparam logic [1:0] OSC_HS = 2'b10;
  localparam logic [1:0] OSC_RC = 2'b11;

  // Sequencer states
  typedef enum logic [5:0] {
    ST_POR   = 6'h01,
    ST_POWER_UP_TIMER  = 6'h02,
    ST_OST   = 6'h04,
    ST_HOLD  = 6'h08,
    ST_RUN   = 6'h10,
    ST_SLEEP = 6'h20
  } rtseq_state_t;

  // Reset cause codes
  localparam logic [2:0] CAUSE_POR        = 3'h0;
  localparam logic [2:0] CAUSE_MASTER_CLEAR_PIN_RUN   = 3'h1;
  localparam logic [2:0] CAUSE_MASTER_CLEAR_PIN_SLEEP = 3'h2;
  localparam logic [2:0] CAUSE_WDT_RESET  = 3'h3;
  localparam logic [2:0] CAUSE_WDT_WAKE   = 3'h4;
  localparam logic [2:0] CAUSE_IRQ_WAKE   = 3'h5;

endpackage

// ==== verilog/rtseq_top.sv ====
// Function
// - Distinguish power-on, clear-run, clear-sleep, watchdog resets.
// - Resets load defaults; watchdog wake leaves registers except the status flags and the timer 2 period.
// - Some registers never reset, keep value.
// - Clear pin filtered against short low glitches.
// - Watchdog reset never drives clear pin.
// - Power-up timer 72 ms, only from power-on.
// - Internal reset held while power-up timer counts.
// - Then 1024 oscillator edges before release.
// - Oscillator timer only crystal modes, power-on or wake.
// - Power-on delay, then power-up timer, then oscillator.
// - Total delay follows oscillator mode and enable.
// - RC mode, timer disabled: no delay at all.
// - Timers ignore clear pin; release starts immediately.
// - Power-on flag cleared on power-on only.
// - After power-on: flag 0, timeout 1, power-down 1.
// - Watchdog clears timeout; power-down shows run or sleep.
// - Clear-sleep and irq wake set 1,0; clear-run unchanged.
// - Reset loads 000h; wake continues or vectors 0004h.
// - Status resets 0001 1xxx power-on, 0000 1uuu watchdog.
// - Port direction all ones on resets, held on wake.
// - Timer 2 period all ones on every condition.
// - Interrupt control resets keeping its lowest bit.
// - Configuration bits active when programmed as zero.
// - Two select bits choose four oscillator modes.
module rtseq_top #(
  parameter int POWER_UP_TIMER_RC_TICKS = rtseq_pkg::POWER_UP_TIMER_TICKS,
  parameter int OST_OSC_CYCLES = rtseq_pkg::OST_CYCLES,
  parameter int MASTER_CLEAR_PIN_FILTER_TICKS = rtseq_pkg::MASTER_CLEAR_PIN_FILT_TICKS
) (
  // Clock and bus reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Pins and analog sources
  input  wire logic        supply_rise,
  input  wire logic        master_clear_pin_n,
  output logic             master_clear_pin_o,
  output logic             master_clear_pin_oe_n,
  input  wire logic        rc_clock_in,
  input  wire logic        oscillator_input,
  // Configuration fuses
  input  wire logic        power_up_timer_enable_n,
  input  wire logic        osc_select_hi,
  input  wire logic        osc_select_lo,
  // Core events
  input  wire logic        watchdog_timeout,
  input  wire logic        sleep_request,
  input  wire logic        irq_wake,
  input  wire logic [12:0] cpu_pc,
  // Core controls
  output logic             core_reset_n,
  output logic             core_run,
  output logic             pc_load,
  output logic [12:0]      pc_load_addr,
  // Reset values seen by the core
  output logic [7:0]       status_reg,
  output logic [7:0]       power_control_register,
  output logic [7:0]       interrupt_control_register,
  output logic [7:0]       port_b_direction_register,
  output logic [7:0]       timer2_period_register
);

  localparam int PW = $clog2(POWER_UP_TIMER_RC_TICKS + 1);
  localparam int OW = $clog2(OST_OSC_CYCLES + 1);
  localparam int FW = $clog2(MASTER_CLEAR_PIN_FILTER_TICKS + 1);

  rtseq_pkg::rtseq_state_t state_reg;  // Sequencer state
  logic          por_s1_reg;           // Power-on release chain
  logic          por_s2_reg;
  logic          master_clear_pin_s1_reg;          // Clear pin synchroniser
  logic          master_clear_pin_s2_reg;
  logic          rc_s1_reg;            // RC clock synchroniser
  logic          rc_s2_reg;
  logic          rc_s3_reg;            // Edge detect stage
  logic          osc_s1_reg;           // Oscillator synchroniser
  logic          osc_s2_reg;
  logic          osc_s3_reg;
  logic          master_clear_pin_filt_reg;        // Filtered clear level, high = released
  logic [FW-1:0] filt_cnt_reg;         // Glitch counter
  logic [PW-1:0] power_up_timer_cnt_reg;         // Power-up timer
  logic [OW-1:0] ost_cnt_reg;          // Oscillator start-up timer
  logic          waking_reg;           // Oscillator timer started by a wake
  logic [2:0]    cause_reg;            // Last reset cause
  logic [7:0]    scratch_reg;          // No reset action
  logic          wr_pend_reg;          // Write in data phase
  logic [7:0]    wr_addr_reg;          // Its offset

  logic rc_tick;      // One cycle per RC rising edge
  logic osc_tick;     // One cycle per oscillator rising edge
  logic por_active;   // Power-on pulse in force
  logic crystal;      // Crystal or resonator mode
  logic power_up_timer_on;      // Power-up timer enabled
  logic evt_por;      // Power-on condition
  logic evt_master_clear_pin_run;
  logic evt_master_clear_pin_slp;
  logic evt_wdt_rst;
  logic evt_wdt_wake;
  logic evt_irq_wake;
  logic evt_reset;    // Any full reset
  logic evt_wake;     // Any wake-up
  logic power_up_timer_done;
  logic ost_done;
  logic addr_ok;      // Valid address phase

  // Upper address bits select the register window
  function automatic logic reg_hit(input logic [31:0] a);
    reg_hit = (a[31:8] == 24'h000000);
  endfunction

  // Power-on release, async assert and sync release
  always_ff @(posedge hclk or negedge hresetn or posedge supply_rise) begin
    if (!hresetn || supply_rise) begin
      por_s1_reg <= 1'b0;
      por_s2_reg <= 1'b0;
    end else begin
      por_s1_reg <= 1'b1;
      por_s2_reg <= por_s1_reg;
    end
  end
  assign por_active = !por_s2_reg;

  // Pin synchronisers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      master_clear_pin_s1_reg <= 1'b1;
      master_clear_pin_s2_reg <= 1'b1;
      rc_s1_reg   <= 1'b0;
      rc_s2_reg   <= 1'b0;
      rc_s3_reg   <= 1'b0;
      osc_s1_reg  <= 1'b0;
      osc_s2_reg  <= 1'b0;
      osc_s3_reg  <= 1'b0;
    end else begin
      master_clear_pin_s1_reg <= master_clear_pin_n;
      master_clear_pin_s2_reg <= master_clear_pin_s1_reg;
      rc_s1_reg   <= rc_clock_in;
      rc_s2_reg   <= rc_s1_reg;
      rc_s3_reg   <= rc_s2_reg;
      osc_s1_reg  <= oscillator_input;
      osc_s2_reg  <= osc_s1_reg;
      osc_s3_reg  <= osc_s2_reg;
    end
  end
  assign rc_tick  = rc_s2_reg && !rc_s3_reg;
  assign osc_tick = osc_s2_reg && !osc_s3_reg;

  // Clear pin glitch filter on RC ticks
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      master_clear_pin_filt_reg <= 1'b1;
      filt_cnt_reg  <= '0;
    end else if (master_clear_pin_s2_reg == master_clear_pin_filt_reg) begin
      filt_cnt_reg <= '0;
    end else if (rc_tick) begin
      if (filt_cnt_reg == FW'(MASTER_CLEAR_PIN_FILTER_TICKS - 1)) begin
        master_clear_pin_filt_reg <= master_clear_pin_s2_reg;
        filt_cnt_reg  <= '0;
      end else begin
        filt_cnt_reg <= filt_cnt_reg + 1'b1;
      end
    end
  end

  // Configuration decode, programmed reads as zero
  assign power_up_timer_on = !power_up_timer_enable_n;
  assign crystal = ({osc_select_hi, osc_select_lo} != rtseq_pkg::OSC_RC);

  // Reset and wake events
  assign evt_por      = por_active;
  assign evt_master_clear_pin_run = !por_active && state_reg == rtseq_pkg::ST_RUN && !master_clear_pin_filt_reg;
  assign evt_master_clear_pin_slp = !por_active && state_reg == rtseq_pkg::ST_SLEEP && !master_clear_pin_filt_reg;
  assign evt_wdt_rst  = !por_active && state_reg == rtseq_pkg::ST_RUN && master_clear_pin_filt_reg
                        && watchdog_timeout;
  assign evt_wdt_wake = !por_active && state_reg == rtseq_pkg::ST_SLEEP && master_clear_pin_filt_reg
                        && watchdog_timeout;
  assign evt_irq_wake = !por_active && state_reg == rtseq_pkg::ST_SLEEP && master_clear_pin_filt_reg
                        && !watchdog_timeout && irq_wake;
  assign evt_reset = evt_por || evt_master_clear_pin_run || evt_master_clear_pin_slp || evt_wdt_rst;
  assign evt_wake  = evt_wdt_wake || evt_irq_wake;
  assign power_up_timer_done = rc_tick && power_up_timer_cnt_reg == PW'(POWER_UP_TIMER_RC_TICKS - 1);
  assign ost_done  = osc_tick && ost_cnt_reg == OW'(OST_OSC_CYCLES - 1);

  // Sequencer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg  <= rtseq_pkg::ST_POR;
      waking_reg <= 1'b0;
    end else if (por_active) begin
      state_reg  <= rtseq_pkg::ST_POR;
      waking_reg <= 1'b0;
    end else begin
      case (state_reg)
        // Power-on delay over: timer, oscillator, or straight on
        rtseq_pkg::ST_POR: begin
          if (power_up_timer_on) begin
            state_reg <= rtseq_pkg::ST_POWER_UP_TIMER;
          end else if (crystal) begin
            state_reg <= rtseq_pkg::ST_OST;
          end else begin
            state_reg <= rtseq_pkg::ST_HOLD;
          end
        end
        // Power-up timer ignores the clear pin
        rtseq_pkg::ST_POWER_UP_TIMER: begin
          if (power_up_timer_done) begin
            state_reg <= crystal ? rtseq_pkg::ST_OST : rtseq_pkg::ST_HOLD;
          end
        end
        // Oscillator timer after power-on or wake
        rtseq_pkg::ST_OST: begin
          if (ost_done) begin
            state_reg  <= waking_reg ? rtseq_pkg::ST_RUN : rtseq_pkg::ST_HOLD;
            waking_reg <= 1'b0;
          end
        end
        // Held by the pin; release runs at once
        rtseq_pkg::ST_HOLD: begin
          if (master_clear_pin_filt_reg) begin
            state_reg <= rtseq_pkg::ST_RUN;
          end
        end
        // Running
        rtseq_pkg::ST_RUN: begin
          if (evt_master_clear_pin_run || evt_wdt_rst) begin
            state_reg <= rtseq_pkg::ST_HOLD;
          end else if (sleep_request) begin
            state_reg <= rtseq_pkg::ST_SLEEP;
          end
        end
        // Sleeping
        rtseq_pkg::ST_SLEEP: begin
          if (evt_master_clear_pin_slp) begin
            state_reg <= rtseq_pkg::ST_HOLD;
          end else if (evt_wake && crystal) begin
            state_reg  <= rtseq_pkg::ST_OST;
            waking_reg <= 1'b1;
          end else if (evt_wake) begin
            state_reg <= rtseq_pkg::ST_RUN;
          end
        end
        default: state_reg <= rtseq_pkg::ST_POR;
      endcase
    end
  end

  // Power-up timer, started from power-on only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      power_up_timer_cnt_reg <= '0;
    end else if (state_reg != rtseq_pkg::ST_POWER_UP_TIMER) begin
      power_up_timer_cnt_reg <= '0;
    end else if (rc_tick) begin
      power_up_timer_cnt_reg <= power_up_timer_cnt_reg + 1'b1;
    end
  end

  // Oscillator start-up timer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ost_cnt_reg <= '0;
    end else if (state_reg != rtseq_pkg::ST_OST) begin
      ost_cnt_reg <= '0;
    end else if (osc_tick) begin
      ost_cnt_reg <= ost_cnt_reg + 1'b1;
    end
  end

  // Core controls; reset held through both power-up timers, except the oscillator timer after a wake
  assign core_reset_n = !(state_reg == rtseq_pkg::ST_POR || state_reg == rtseq_pkg::ST_POWER_UP_TIMER
                        || state_reg == rtseq_pkg::ST_HOLD
                        || (state_reg == rtseq_pkg::ST_OST && !waking_reg));
  assign core_run = state_reg == rtseq_pkg::ST_RUN;
  // Pin is input only, watchdog never pulls it
  assign master_clear_pin_o    = 1'b1;
  assign master_clear_pin_oe_n = 1'b1;

  // Program counter load and cause record
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pc_load      <= 1'b0;
      pc_load_addr <= rtseq_pkg::PC_RESET_VEC;
      cause_reg    <= rtseq_pkg::CAUSE_POR;
    end else begin
      pc_load <= evt_reset || evt_wake;
      if (evt_reset) begin
        pc_load_addr <= rtseq_pkg::PC_RESET_VEC;
      end else if (evt_irq_wake && interrupt_control_register[rtseq_pkg::INT_GIE_BIT]) begin
        pc_load_addr <= rtseq_pkg::PC_IRQ_VEC;
      end else if (evt_wake) begin
        pc_load_addr <= cpu_pc + 13'h0001;
      end
      if (evt_por) cause_reg <= rtseq_pkg::CAUSE_POR;
      else if (evt_master_clear_pin_run) cause_reg <= rtseq_pkg::CAUSE_MASTER_CLEAR_PIN_RUN;
      else if (evt_master_clear_pin_slp) cause_reg <= rtseq_pkg::CAUSE_MASTER_CLEAR_PIN_SLEEP;
      else if (evt_wdt_rst) cause_reg <= rtseq_pkg::CAUSE_WDT_RESET;
      else if (evt_wdt_wake) cause_reg <= rtseq_pkg::CAUSE_WDT_WAKE;
      else if (evt_irq_wake) cause_reg <= rtseq_pkg::CAUSE_IRQ_WAKE;
    end
  end

  // Bus address phase capture, zero wait states
  assign addr_ok = hsel && hready && htrans[1];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata      <= 32'h00000000;
    end else begin
      wr_pend_reg <= addr_ok && hwrite && reg_hit(haddr);
      wr_addr_reg <= haddr[7:0];
      if (addr_ok && !hwrite && !reg_hit(haddr)) begin
        hrdata <= 32'h00000000;  // Outside the register window
      end else if (addr_ok && !hwrite) begin
        case (haddr[7:0])
          rtseq_pkg::OFS_STATUS:    hrdata <= {24'h0, status_reg};
          rtseq_pkg::OFS_PWRCTL:    hrdata <= {24'h0, power_control_register};
          rtseq_pkg::OFS_INTCTL:    hrdata <= {24'h0, interrupt_control_register};
          rtseq_pkg::OFS_PORTB_DIR: hrdata <= {24'h0, port_b_direction_register};
          rtseq_pkg::OFS_T2_PERIOD: hrdata <= {24'h0, timer2_period_register};
          rtseq_pkg::OFS_SCRATCH:   hrdata <= {24'h0, scratch_reg};
          rtseq_pkg::OFS_SEQ_STAT:  hrdata <= {21'h0, cause_reg, 2'b00, state_reg};
          default:                  hrdata <= 32'h00000000;  // Unmapped reads zero
        endcase
      end
    end
  end
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Status image: timeout and power-down flags, events beat writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_reg <= rtseq_pkg::STATUS_POR_VAL;
    end else if (evt_por) begin
      status_reg <= rtseq_pkg::STATUS_POR_VAL | (status_reg & 8'h07);
    end else if (evt_master_clear_pin_run) begin
      status_reg <= status_reg & 8'h1F;
    end else if (evt_master_clear_pin_slp) begin
      status_reg <= (status_reg & 8'h07) | 8'h10;
    end else if (evt_wdt_rst) begin
      status_reg <= (status_reg & 8'h07) | 8'h08;
    end else if (evt_wdt_wake) begin
      status_reg <= status_reg & 8'hE7;
    end else if (evt_irq_wake) begin
      status_reg <= (status_reg & 8'hE7) | 8'h10;
    end else if (wr_pend_reg && wr_addr_reg == rtseq_pkg::OFS_STATUS) begin
      status_reg <= (hwdata[7:0] & rtseq_pkg::STATUS_RW_MASK)
                    | (status_reg & ~rtseq_pkg::STATUS_RW_MASK);
    end
  end

  // Power control: flag cleared only by power-on
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      power_control_register <= rtseq_pkg::PWRCTL_RST_VAL;
    end else if (evt_por) begin
      power_control_register <= rtseq_pkg::PWRCTL_RST_VAL;
    end else if (wr_pend_reg && wr_addr_reg == rtseq_pkg::OFS_PWRCTL) begin
      power_control_register <= hwdata[7:0] & rtseq_pkg::PWRCTL_RW_MASK;
    end
  end

  // Interrupt control keeps bit 0 through resets
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      interrupt_control_register <= rtseq_pkg::INTCTL_RST_VAL;
    end else if (evt_reset) begin
      interrupt_control_register <= {7'h00, interrupt_control_register[0]};
    end else if (wr_pend_reg && wr_addr_reg == rtseq_pkg::OFS_INTCTL) begin
      interrupt_control_register <= hwdata[7:0];
    end
  end

  // Port direction, held across wake
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_b_direction_register <= rtseq_pkg::DIR_RST_VAL;
    end else if (evt_reset) begin
      port_b_direction_register <= rtseq_pkg::DIR_RST_VAL;
    end else if (wr_pend_reg && wr_addr_reg == rtseq_pkg::OFS_PORTB_DIR) begin
      port_b_direction_register <= hwdata[7:0];
    end
  end

  // Timer 2 period forced on every condition
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer2_period_register <= rtseq_pkg::T2_PERIOD_VAL;
    end else if (evt_reset || evt_wake) begin
      timer2_period_register <= rtseq_pkg::T2_PERIOD_VAL;
    end else if (wr_pend_reg && wr_addr_reg == rtseq_pkg::OFS_T2_PERIOD) begin
      timer2_period_register <= hwdata[7:0];
    end
  end

  // Scratch register has no reset at all
  always_ff @(posedge hclk) begin
    if (wr_pend_reg && wr_addr_reg == rtseq_pkg::OFS_SCRATCH) begin
      scratch_reg <= hwdata[7:0];
    end
  end

  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_power_up_timer_hold;
    state_reg == rtseq_pkg::ST_POWER_UP_TIMER |-> !core_reset_n;
  endproperty
  a_power_up_timer_hold: assert property (p_power_up_timer_hold) else $error("reset released early");

  property p_por_flags;
    $fell(por_active) |-> status_reg[4:3] == 2'b11 && !power_control_register[1];
  endproperty
  a_por_flags: assert property (p_por_flags) else $error("power-on flags wrong");

  property p_wdt_rst;
    evt_wdt_rst |=> status_reg[4:3] == 2'b01 && pc_load && pc_load_addr == 13'h0000;
  endproperty
  a_wdt_rst: assert property (p_wdt_rst) else $error("watchdog reset flags wrong");

  property p_master_clear_pin_slp;
    evt_master_clear_pin_slp |=> status_reg[4:3] == 2'b10 ##1 !core_reset_n;
  endproperty
  a_master_clear_pin_slp: assert property (p_master_clear_pin_slp) else $error("clear in sleep wrong");

  property p_t2;
    evt_reset || evt_wake |=> timer2_period_register == 8'hFF;
  endproperty
  a_t2: assert property (p_t2) else $error("timer 2 period not forced");

  property p_rc_nodelay;
    state_reg == rtseq_pkg::ST_POR && !por_active && !power_up_timer_on && !crystal && master_clear_pin_filt_reg
      |=> ##1 core_run;
  endproperty
  a_rc_nodelay: assert property (p_rc_nodelay) else $error("RC start delayed");

  property p_ost_end;
    state_reg == rtseq_pkg::ST_OST && ost_done |=> state_reg != rtseq_pkg::ST_OST;
  endproperty
  a_ost_end: assert property (p_ost_end) else $error("oscillator timer overran");

  property p_pin_free;
    watchdog_timeout |-> master_clear_pin_oe_n;
  endproperty
  a_pin_free: assert property (p_pin_free) else $error("clear pin driven");

  property p_irq_vec;
    evt_irq_wake && interrupt_control_register[7] |=> pc_load_addr == 13'h0004;
  endproperty
  a_irq_vec: assert property (p_irq_vec) else $error("wake vector wrong");

  property p_wake_keep;
    evt_wdt_wake |=> $stable(port_b_direction_register);
  endproperty
  a_wake_keep: assert property (p_wake_keep) else $error("direction changed on wake");

  c_por_run: cover property ($fell(por_active) ##[1:1000] core_run);
  c_wdt_wake: cover property (evt_wdt_wake);
  c_irq_vec: cover property (evt_irq_wake && interrupt_control_register[7]);
  c_master_clear_pin_run: cover property (evt_master_clear_pin_run);

endmodule
